// >>> ofs_adc_model.sv
// Behavioural converter answering the sequencer's start pulses
`default_nettype none
module ofs_adc_model
(
    // Clock, reset and control
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        start_in,
    input  wire logic [7:0]  delay_in,
    // Conversion outputs
    output logic             done_out,
    output logic      [15:0] data_out,
    output logic      [15:0] last_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt; // Cycles left in the conversion
    // =================================================================
    // Conversion: data churns while busy, settles, then done rises
    always @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cnt      <= 0;
            done_out <= 1'b0;
            data_out <= 16'h0000;
            last_out <= 16'h0000;
        end
        else if (start_in)
        begin
            cnt      <= int'(delay_in) + 3;
            done_out <= 1'b0;
        end
        else if (cnt > 2)
        begin
            // Not valid yet: pattern changes every cycle
            cnt      <= cnt - 1;
            data_out <= ~data_out;
        end
        else if (cnt == 2)
        begin
            // Result settles a cycle before done rises
            cnt      <= 1;
            data_out <= last_out + 16'h3a5d;
            last_out <= last_out + 16'h3a5d;
        end
        else if (cnt == 1)
        begin
            cnt      <= 0;
            done_out <= 1'b1;
        end
    end
endmodule // ofs_adc_model
`default_nettype wire

// >>> ofs_cfg.svh
// Register map, reset values and timing counts of the optical sequencer
`ifndef OFS_CFG_SVH
`define OFS_CFG_SVH
// =====================================================================
// Register byte offsets
`define OFS_AMP_CFG_ADDR   8'h0c
`define OFS_DIV_CNT_ADDR   8'h24
`define OFS_START_ADDR     8'h28
`define OFS_PERIOD_ADDR    8'h2c
`define OFS_LED_ADDR       8'h30
`define OFS_ITG_ADDR       8'h34
`define OFS_SDP_ADDR       8'h38
`define OFS_NEGA_ADDR      8'h3c
`define OFS_NEGB_ADDR      8'h40
`define OFS_ADC_POS_ADDR   8'h44
`define OFS_ADC_INC_ADDR   8'h48
`define OFS_SUBS_ADDR      8'h4c
`define OFS_MANUAL_ADDR    8'h50
`define OFS_RESULT_ADDR    8'h54
// =====================================================================
// Field positions
`define OFS_AMP_EN_BIT     31
`define OFS_START_BIT      0
`define OFS_MAN_MODE_BIT   0
`define OFS_MAN_ITG_BIT    1
// =====================================================================
// Reset values
`define OFS_TRIM_RST       4'hf
`define OFS_COMP_RST       2'h3
`define OFS_ITG_ON_RST     16'h0001
// =====================================================================
// Timing: base period and clock period in ns
`define OFS_BASE_NS        1000
`define OFS_CLK_NS         40
`define OFS_BASE_CYC       (`OFS_BASE_NS / `OFS_CLK_NS)
`endif

// >>> ofs_pkg.sv
// Types shared by the optical sequencer
`default_nettype none
package ofs_pkg;
    // Sequencer states, one-hot
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_CONV = 3'b100
    } ofs_state_e;
endpackage : ofs_pkg
`default_nettype wire

// >>> ofs_top.sv
// Optical front end sequencer with amplifier config and AHB-Lite slave
//
// Chosen here: the AHB-Lite register port.
`include "ofs_cfg.svh"
`default_nettype none
// What this block does
// - Integrate from sequencer, or manual bit
// - Manual mode drives LEDs, integrator, ADC
// - Config bit 31 enables photo amplifier
// - Bits 7:5 select feedback resistor
// - Bits 4:0 select feedback capacitor
// - Trim resets 15, compensation resets 3
// - All window timings are 16 bits
// - Sequencer results go to result register
// - Timing registers act only outside manual
// - Write 1 starts, 0 stops sequencer
// - Run stops after measurement count cycles
// - Tick divides the 1 us base
// - Period sets cycle length, then restart
// - LEDs follow programmed start and stop
// - Integrator follows its start and stop
// - Positive phase follows its window
// - Two negative phases, own windows each
// - Sample point: ticks plus sixteenths
// - Sample point advances after each cycle
// - Subsampling divides ADC sample rate
// - Tick period is divider plus one us
// - Count zero runs continuously
// - Run bit reads busy until done
// - LEDs turn on one tick late
module ofs_top
(
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RST_B_IN,
    // AHB-Lite slave
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    // ADC
    input  wire logic        ADC_DONE_IN,
    input  wire logic [15:0] ADC_DATA_IN,
    output logic             ADC_START_OUT,
    // Front end controls
    output logic      [3:0]  LED_OUT,
    output logic             INTEGRATE_OUT,
    output logic             SD_POS_OUT,
    output logic             SD_NEG_A_OUT,
    output logic             SD_NEG_B_OUT,
    // Amplifier configuration
    output logic             AMP_ENABLE_OUT,
    output logic      [2:0]  FB_RES_OUT,
    output logic      [4:0]  FB_CAP_OUT,
    output logic      [3:0]  OFFSET_TRIM_OUT,
    output logic      [1:0]  COMP_OUT
);
    // =================================================================
    // Declarations
    localparam logic [4:0] BASE_CYC = 5'(`OFS_BASE_CYC); // Clocks per us
    ofs_pkg::ofs_state_e state;          // Sequencer state
    logic        wr_pend;                // Write data phase pending
    logic [7:0]  wr_addr;                // Latched write address
    logic [31:0] rd_val;                 // Read mux
    logic        ap;                     // Valid address phase
    logic [15:0] div, per;               // Divider, period
    logic [7:0]  cnt, subs;              // Count, subsample ratio
    logic [15:0] led_on, led_off;        // LED window
    logic [15:0] itg_on, itg_off;        // Integrator window
    logic [15:0] sdp_on, sdp_off;        // Positive phase window
    logic [15:0] neg_phase_a_on_time, neg_phase_a_off_time;
    logic [15:0] neg_phase_b_on_time, neg_phase_b_off_time;
    logic [19:0] adc_pos_cfg, adc_inc;   // Integer and sixteenths
    logic        man_mode, manual_integrate;
    logic [3:0]  man_led;                // Manual LED bits
    logic        photo_amp_enable;       // Amplifier fields
    logic [3:0]  amp_offset_trim;
    logic [1:0]  amp_compensation;
    logic [2:0]  feedback_resistor_sel;
    logic [4:0]  feedback_capacitor_sel;
    logic [15:0] result;                 // Last ADC result
    logic [4:0]  us_cnt;                 // Base prescaler
    logic [15:0] div_cnt;                // Tick divider
    logic [15:0] t;                      // In-cycle time
    logic [21:0] sub_clk;                // Clocks inside tick
    logic [19:0] pos;                    // Live sample position
    logic [7:0]  sub_cnt, meas;          // Subsample, measurement
    logic        us_pulse, tick, cyc_end, fire, run;
    logic [21:0] tick_clk, thr;          // Tick length, fraction point
    logic        wr_start;               // Start register write
    logic [2:0]  done_s;                 // ADC done sync and edge
    logic [15:0] data_s1, data_s2;       // ADC data sync
    logic        done_rise;
    // =================================================================
    // Bus decode
    assign ap       = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    assign wr_start = wr_pend && (wr_addr == `OFS_START_ADDR);
    assign run      = (state == ofs_pkg::ST_RUN);

    // Read mux, unmapped reads zero
    always_comb
    begin
        unique case (HADDR_IN[7:0])
            `OFS_AMP_CFG_ADDR: rd_val = {photo_amp_enable, 17'h0,
                amp_offset_trim, amp_compensation,
                feedback_resistor_sel, feedback_capacitor_sel};
            `OFS_DIV_CNT_ADDR: rd_val = {8'h0, div, cnt};
            `OFS_START_ADDR:   rd_val = {31'h0, state != ofs_pkg::ST_IDLE};
            `OFS_PERIOD_ADDR:  rd_val = {16'h0, per};
            `OFS_LED_ADDR:     rd_val = {led_on, led_off};
            `OFS_ITG_ADDR:     rd_val = {itg_on, itg_off};
            `OFS_SDP_ADDR:     rd_val = {sdp_on, sdp_off};
            `OFS_NEGA_ADDR:    rd_val = {neg_phase_a_on_time,
                                         neg_phase_a_off_time};
            `OFS_NEGB_ADDR:    rd_val = {neg_phase_b_on_time,
                                         neg_phase_b_off_time};
            `OFS_ADC_POS_ADDR: rd_val = {12'h0, adc_pos_cfg};
            `OFS_ADC_INC_ADDR: rd_val = {12'h0, adc_inc};
            `OFS_SUBS_ADDR:    rd_val = {24'h0, subs};
            `OFS_MANUAL_ADDR:  rd_val = {26'h0, man_led,
                                         manual_integrate, man_mode};
            `OFS_RESULT_ADDR:  rd_val = {16'h0, result};
            default:           rd_val = 32'h0;
        endcase
    end

    // Zero-wait slave: read data set at address phase edge
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            wr_pend       <= 1'b0;
            wr_addr       <= 8'h0;
            HRDATA_OUT    <= 32'h0;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
        end
        else
        begin
            wr_pend       <= ap && HWRITE_IN;
            wr_addr       <= HADDR_IN[7:0];
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
            if (ap && !HWRITE_IN)
                HRDATA_OUT <= rd_val;
        end
    end

    // =================================================================
    // Configuration registers, written in data phase
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            photo_amp_enable       <= 1'b0;
            amp_offset_trim        <= `OFS_TRIM_RST;
            amp_compensation       <= `OFS_COMP_RST;
            feedback_resistor_sel  <= 3'h0;
            feedback_capacitor_sel <= 5'h0;
            {div, cnt, per}        <= 40'h0;
            {led_on, led_off}      <= 32'h0;
            itg_on                 <= `OFS_ITG_ON_RST;
            itg_off                <= 16'h0;
            {sdp_on, sdp_off}      <= 32'h0;
            {neg_phase_a_on_time, neg_phase_a_off_time} <= 32'h0;
            {neg_phase_b_on_time, neg_phase_b_off_time} <= 32'h0;
            {adc_pos_cfg, adc_inc} <= 40'h0;
            subs                   <= 8'h0;
            {man_led, manual_integrate, man_mode} <= 6'h0;
        end
        else if (wr_pend)
        begin
            unique case (wr_addr)
                `OFS_AMP_CFG_ADDR:
                begin
                    photo_amp_enable <= HWDATA_IN[`OFS_AMP_EN_BIT];
                    amp_offset_trim        <= HWDATA_IN[13:10];
                    amp_compensation       <= HWDATA_IN[9:8];
                    feedback_resistor_sel  <= HWDATA_IN[7:5];
                    feedback_capacitor_sel <= HWDATA_IN[4:0];
                end
                `OFS_DIV_CNT_ADDR: {div, cnt} <= HWDATA_IN[23:0];
                `OFS_PERIOD_ADDR:  per <= HWDATA_IN[15:0];
                `OFS_LED_ADDR:     {led_on, led_off} <= HWDATA_IN;
                `OFS_ITG_ADDR:     {itg_on, itg_off} <= HWDATA_IN;
                `OFS_SDP_ADDR:     {sdp_on, sdp_off} <= HWDATA_IN;
                `OFS_NEGA_ADDR:    {neg_phase_a_on_time,
                                    neg_phase_a_off_time} <= HWDATA_IN;
                `OFS_NEGB_ADDR:    {neg_phase_b_on_time,
                                    neg_phase_b_off_time} <= HWDATA_IN;
                `OFS_ADC_POS_ADDR: adc_pos_cfg <= HWDATA_IN[19:0];
                `OFS_ADC_INC_ADDR: adc_inc <= HWDATA_IN[19:0];
                `OFS_SUBS_ADDR:    subs <= HWDATA_IN[7:0];
                `OFS_MANUAL_ADDR:  {man_led, manual_integrate, man_mode}
                                       <= HWDATA_IN[5:0];
                default: ;
            endcase
        end
    end

    // =================================================================
    // ADC handshake synchronisers
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            done_s  <= 3'h0;
            data_s1 <= 16'h0;
            data_s2 <= 16'h0;
        end
        else
        begin
            done_s  <= {done_s[1:0], ADC_DONE_IN};
            data_s1 <= ADC_DATA_IN;
            data_s2 <= data_s1;
        end
    end
    assign done_rise = done_s[1] && !done_s[2];

    // Result register catches each finished conversion
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            result <= 16'h0;
        else if (done_rise)
            result <= data_s2;
    end

    // =================================================================
    // Time base: 1 us pulse, then divided tick
    assign us_pulse = run && (us_cnt == BASE_CYC - 5'h1);
    assign tick     = us_pulse && (div_cnt == div);
    assign cyc_end  = tick && (t == per - 16'h1);
    assign tick_clk = 22'({1'b0, div} + 17'h1) * 22'(BASE_CYC);
    assign thr      = 22'((26'(pos[3:0]) * 26'(tick_clk)) >> 4);
    // Sample instant inside its subsampled cycle
    assign fire = run && !man_mode && (sub_cnt == 8'h0)
                  && (t == pos[19:4]) && (sub_clk == thr);

    // Prescaler, divider and in-cycle counters
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            us_cnt  <= 5'h0;
            div_cnt <= 16'h0;
            t       <= 16'h0;
            sub_clk <= 22'h0;
        end
        else if (!run)
        begin
            {us_cnt, div_cnt, t, sub_clk} <= 59'h0;
        end
        else
        begin
            us_cnt  <= us_pulse ? 5'h0 : us_cnt + 5'h1;
            sub_clk <= tick ? 22'h0 : sub_clk + 22'h1;
            if (us_pulse)
                div_cnt <= tick ? 16'h0 : div_cnt + 16'h1;
            if (tick)
                t <= cyc_end ? 16'h0 : t + 16'h1;
        end
    end

    // Sample position, subsampling and measurement count
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            pos     <= 20'h0;
            sub_cnt <= 8'h0;
            meas    <= 8'h0;
        end
        else if (!run)
        begin
            pos     <= adc_pos_cfg;
            sub_cnt <= 8'h0;
            meas    <= 8'h0;
        end
        else if (cyc_end)
        begin
            pos     <= pos + adc_inc;
            sub_cnt <= (sub_cnt + 8'h1 >= subs) ? 8'h0
                       : sub_cnt + 8'h1;
            meas    <= meas + 8'h1;
        end
    end

    // =================================================================
    // Run control state machine
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            state <= ofs_pkg::ST_IDLE;
        else
        begin
            unique case (state)
                ofs_pkg::ST_IDLE:
                    if (wr_start && HWDATA_IN[`OFS_START_BIT])
                        state <= man_mode ? ofs_pkg::ST_CONV
                                          : ofs_pkg::ST_RUN;
                ofs_pkg::ST_RUN:
                    if (wr_start && !HWDATA_IN[`OFS_START_BIT])
                        state <= ofs_pkg::ST_IDLE;
                    else if (cyc_end && cnt != 8'h0
                             && meas == cnt - 8'h1)
                        state <= ofs_pkg::ST_IDLE;
                ofs_pkg::ST_CONV:
                    if (done_rise)
                        state <= ofs_pkg::ST_IDLE;
                default:
                    state <= ofs_pkg::ST_IDLE;
            endcase
        end
    end

    // =================================================================
    // Output drive: manual bits or sequencer windows
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            LED_OUT       <= 4'h0;
            INTEGRATE_OUT <= 1'b0;
            SD_POS_OUT    <= 1'b0;
            SD_NEG_A_OUT  <= 1'b0;
            SD_NEG_B_OUT  <= 1'b0;
            ADC_START_OUT <= 1'b0;
        end
        else if (man_mode)
        begin
            LED_OUT       <= man_led;
            INTEGRATE_OUT <= manual_integrate;
            SD_POS_OUT    <= 1'b0;
            SD_NEG_A_OUT  <= 1'b0;
            SD_NEG_B_OUT  <= 1'b0;
            ADC_START_OUT <= state == ofs_pkg::ST_IDLE && wr_start
                             && HWDATA_IN[`OFS_START_BIT];
        end
        else
        begin
            // Window on from start until before stop
            if (tick)
                LED_OUT <= {4{t >= led_on && t < led_off}};
            else if (!run)
                LED_OUT <= 4'h0;
            INTEGRATE_OUT <= run && t >= itg_on && t < itg_off;
            SD_POS_OUT    <= run && t >= sdp_on && t < sdp_off;
            SD_NEG_A_OUT  <= run && t >= neg_phase_a_on_time
                             && t < neg_phase_a_off_time;
            SD_NEG_B_OUT  <= run && t >= neg_phase_b_on_time
                             && t < neg_phase_b_off_time;
            ADC_START_OUT <= fire;
        end
    end

    // Amplifier configuration straight from its register
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            AMP_ENABLE_OUT  <= 1'b0;
            FB_RES_OUT      <= 3'h0;
            FB_CAP_OUT      <= 5'h0;
            OFFSET_TRIM_OUT <= `OFS_TRIM_RST;
            COMP_OUT        <= `OFS_COMP_RST;
        end
        else
        begin
            AMP_ENABLE_OUT  <= photo_amp_enable;
            FB_RES_OUT      <= feedback_resistor_sel;
            FB_CAP_OUT      <= feedback_capacitor_sel;
            OFFSET_TRIM_OUT <= amp_offset_trim;
            COMP_OUT        <= amp_compensation;
        end
    end

    // =================================================================
    // Assertions
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    AST_MAN_ITG: assert property (man_mode && $stable(man_mode)
        |=> INTEGRATE_OUT == $past(manual_integrate))
        else $error("Manual integrate not followed");
    AST_MAN_LED: assert property (man_mode && $stable(man_mode)
        |=> LED_OUT == $past(man_led))
        else $error("Manual LEDs not followed");
    AST_AMP_EN: assert property (wr_pend
        && wr_addr == `OFS_AMP_CFG_ADDR
        |-> ##2 AMP_ENABLE_OUT == $past(HWDATA_IN[31], 2))
        else $error("Amp enable not applied");
    AST_TICK: assert property (tick |-> div_cnt == div
        && us_cnt == BASE_CYC - 5'h1)
        else $error("Tick off divider");
    AST_WRAP: assert property (cyc_end && run
        && !wr_start |=> t == 16'h0)
        else $error("Cycle did not restart");
    AST_LED_LATE: assert property (!man_mode && run && tick
        && t == led_on && led_on < led_off ##1 !man_mode
        |-> LED_OUT == 4'hf)
        else $error("LED not on one tick after start");
    AST_STOP: assert property (run && wr_start
        && !HWDATA_IN[0] |=> state == ofs_pkg::ST_IDLE)
        else $error("Sequencer did not stop");
    AST_COUNT: assert property (run && cyc_end && !wr_start
        && cnt != 8'h0 && meas == cnt - 8'h1
        |=> state == ofs_pkg::ST_IDLE ##1 !ADC_START_OUT)
        else $error("Run did not end at count");
    AST_SAMPLE: assert property (ADC_START_OUT && !man_mode
        && $stable(man_mode) |-> $past(t) == $past(pos[19:4]))
        else $error("Sample at wrong tick");
    AST_BUSY: assert property (state == ofs_pkg::ST_CONV
        && !done_rise |=> state == ofs_pkg::ST_CONV)
        else $error("Conversion busy dropped early");

    COV_RUN: cover property (run && cyc_end);
    COV_CONV: cover property (state == ofs_pkg::ST_CONV ##1 done_rise);
    COV_SAMPLE: cover property (fire);

endmodule // ofs_top
`default_nettype wire

// >>> optical_frontend_sequencer_tb.sv
// Self-checking bench of the optical front end sequencer
`include "ofs_cfg.svh"
`default_nettype none
module optical_frontend_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // =================================================================
    // Design signals
    logic CLK_IN, RST_B_IN, HSEL_IN, HWRITE_IN, ADC_START_OUT;
    logic [31:0] HADDR_IN, HWDATA_IN, HRDATA_OUT, rd, seed;
    logic [1:0] HTRANS_IN, COMP_OUT;
    logic [2:0] HSIZE_IN, FB_RES_OUT;
    logic HREADYOUT_OUT, HRESP_OUT, AMP_ENABLE_OUT, INTEGRATE_OUT;
    logic SD_POS_OUT, SD_NEG_A_OUT, SD_NEG_B_OUT;
    logic [3:0] LED_OUT, OFFSET_TRIM_OUT;
    logic [4:0] FB_CAP_OUT;
    logic [7:0] adc_dly;                     // Converter latency
    wire logic ADC_DONE_IN;
    wire logic [15:0] ADC_DATA_IN, adc_last;
    wire logic HREADY_IN = HREADYOUT_OUT;    // Single slave
    // Outputs packed in register layout, and front end controls
    wire logic [31:0] amp_o = {AMP_ENABLE_OUT, 17'h0, OFFSET_TRIM_OUT,
                               COMP_OUT, FB_RES_OUT, FB_CAP_OUT};
    wire logic [31:0] ctl = {23'h0, LED_OUT, INTEGRATE_OUT, SD_POS_OUT,
                             SD_NEG_A_OUT, SD_NEG_B_OUT, ADC_START_OUT};
    int bad_count, check_count;
    int hi [9];                              // High-cycle counts of ctl
    ofs_top dut (.CLK_IN, .RST_B_IN, .HSEL_IN, .HADDR_IN, .HTRANS_IN,
        .HWRITE_IN, .HSIZE_IN, .HWDATA_IN, .HREADY_IN, .HRDATA_OUT,
        .HREADYOUT_OUT, .HRESP_OUT, .ADC_DONE_IN, .ADC_DATA_IN,
        .ADC_START_OUT, .LED_OUT, .INTEGRATE_OUT, .SD_POS_OUT,
        .SD_NEG_A_OUT, .SD_NEG_B_OUT, .AMP_ENABLE_OUT, .FB_RES_OUT,
        .FB_CAP_OUT, .OFFSET_TRIM_OUT, .COMP_OUT);
    ofs_adc_model adc (.clk_in(CLK_IN), .rst_b_in(RST_B_IN),
        .start_in(ADC_START_OUT), .delay_in(adc_dly),
        .done_out(ADC_DONE_IN), .data_out(ADC_DATA_IN),
        .last_out(adc_last));
    // =================================================================
    // Clock and output monitors
    always #20 CLK_IN = ~CLK_IN;
    always @(posedge CLK_IN)
        foreach (hi[i]) hi[i] += int'(ctl[i]);
    // =================================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected high clocks of one window over four cycles
    function automatic int win(input int on, off, len);
        return (off > on) ? (off - on) * len * 4 : 0;
    endfunction
    task automatic close_out;
        if (bad_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Wait for a sampled hready, bounded
    task automatic edge_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge CLK_IN);
            n++;
        end
        while (HREADYOUT_OUT !== 1'b1 && n < 50);
        if (HREADYOUT_OUT !== 1'b1)
        begin
            bad_count++;
            close_out();
        end
    endtask
    // One single word transfer, address then data phase
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd);
        HSEL_IN   <= 1'b1;
        HTRANS_IN <= 2'b10;
        HWRITE_IN <= w;
        HADDR_IN  <= {24'h000000, a};
        edge_rdy();
        HSEL_IN   <= 1'b0;
        HTRANS_IN <= 2'b00;
        HWDATA_IN <= wd;
        edge_rdy();
        rd = HRDATA_OUT;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    // Poll the run bit until it clears, bounded
    task automatic wait_idle;
        rd = 32'h1;
        for (int n = 0; n < 2000 && rd[0] !== 1'b0; n++)
            xfer(1'b0, `OFS_START_ADDR, 32'h0);
        if (rd[0] !== 1'b0)
        begin
            bad_count++;
            close_out();
        end
    endtask
    // =================================================================
    // Main sequence
    initial
    begin
        logic [31:0] v;
        logic [7:0]  ra [11];
        logic [31:0] rv [11];
        int          tl;
        {bad_count, check_count, CLK_IN, RST_B_IN, HSEL_IN} = '0;
        {HADDR_IN, HTRANS_IN, HWRITE_IN, HWDATA_IN} = '0;
        HSIZE_IN = 3'b010;
        adc_dly = 8'd40;
        seed = 32'h187472d3;
        repeat (2) @(posedge CLK_IN);
        RST_B_IN <= 1'b1;
        chk("amp_rst", amp_o, 32'h00003f00);
        chk("ctl_rst", ctl, 32'h0);
        rdchk("amp_cfg", `OFS_AMP_CFG_ADDR, 32'h00003f00);
        rdchk("div_cnt", `OFS_DIV_CNT_ADDR, 32'h0);
        rdchk("itg", `OFS_ITG_ADDR, 32'h00010000);
        // Every resistor code with random remaining fields
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            v = (seed & 32'hffffff1f) | (32'(i) << 5);
            xfer(1'b1, `OFS_AMP_CFG_ADDR, v);
            rdchk("amp_rd", `OFS_AMP_CFG_ADDR, v & 32'h80003fff);
            chk("amp_out", amp_o, v & 32'h80003fff);
        end
        // Unmapped place: write ignored, reads zero, still OKAY
        xfer(1'b1, 8'h5c, seed);
        rdchk("unmapped", 8'h5c, 32'h0);
        chk("resp", {31'h0, HRESP_OUT}, 32'h0);
        // Manual mode: integrate and LEDs from bits, one conversion
        xfer(1'b1, `OFS_MANUAL_ADDR, 32'h0000002b);
        rdchk("manual", `OFS_MANUAL_ADDR, 32'h0000002b);
        chk("man_ctl", ctl, 32'h00000150);
        hi = '{default: 0};
        xfer(1'b1, `OFS_START_ADDR, 32'h1);
        rdchk("busy", `OFS_START_ADDR, 32'h1);
        wait_idle();
        chk("man_conv", hi[0], 1);
        rdchk("man_res", `OFS_RESULT_ADDR, {16'h0, adc_last});
        xfer(1'b1, `OFS_MANUAL_ADDR, 32'h0);
        // Sequencer: random divider, four cycles, ADC every 2nd
        seed = lfsr(seed);
        tl = (int'(seed % 32'd3) + 1) * 25;
        ra = '{`OFS_AMP_CFG_ADDR, `OFS_DIV_CNT_ADDR, `OFS_PERIOD_ADDR,
               `OFS_LED_ADDR, `OFS_ITG_ADDR, `OFS_SDP_ADDR, `OFS_NEGA_ADDR,
               `OFS_NEGB_ADDR, `OFS_ADC_POS_ADDR, `OFS_ADC_INC_ADDR,
               `OFS_SUBS_ADDR};
        rv = '{32'h80003f20, (32'(tl / 25 - 1) << 8) | 32'h4, 32'h8,
               32'h00020005, 32'h00010006, 32'h00020004, 32'h00040006,
               32'h00060007, 32'h38, 32'h18, 32'h2};
        foreach (ra[i]) xfer(1'b1, ra[i], rv[i]);
        foreach (ra[i]) rdchk("seq_reg", ra[i], rv[i]);
        hi = '{default: 0};
        adc_dly <= 8'd2;
        xfer(1'b1, `OFS_START_ADDR, 32'h1);
        wait_idle();
        chk("led", hi[5], win(2, 5, tl));
        chk("itg_win", hi[4], win(1, 6, tl));
        chk("pos_win", hi[3], win(2, 4, tl));
        chk("neg_a", hi[2], win(4, 6, tl));
        chk("neg_b", hi[1], win(6, 7, tl));
        chk("samples", hi[0], 2);
        rdchk("seq_res", `OFS_RESULT_ADDR, {16'h0, adc_last});
        // Continuous run, manual takeover, then stop
        xfer(1'b1, `OFS_DIV_CNT_ADDR, 32'(tl / 25 - 1) << 8);
        xfer(1'b1, `OFS_START_ADDR, 32'h1);
        repeat (20 * tl) @(posedge CLK_IN);
        rdchk("cont", `OFS_START_ADDR, 32'h1);
        xfer(1'b1, `OFS_MANUAL_ADDR, 32'h0000002b);
        repeat (9 * tl) @(posedge CLK_IN);
        chk("man_run", ctl & 32'h1fe, 32'h00000150);
        xfer(1'b1, `OFS_MANUAL_ADDR, 32'h0);
        xfer(1'b1, `OFS_START_ADDR, 32'h0);
        rdchk("stop", `OFS_START_ADDR, 32'h0);
        chk("stopped", ctl, 32'h0);
        close_out();
    end
endmodule // optical_frontend_sequencer_tb
`default_nettype wire
